// ==== acrs_regs.svh ====
// acrs_regs.svh: timing counts, field positions and reset values
// shared by both ends of the clock, reset and sync sequencer.
// assumes REF_CLK_I is the master clock of the converter end.
`ifndef ACRS_REGS_SVH
`define ACRS_REGS_SVH

// master clock rate and the core clock ceiling after the divide
`define ACRS_MCLK_HZ        20000000
`define ACRS_CORE_MAX_HZ    20000000
`define ACRS_CORE_DIV       2

// host side start-up timing, counted in master clock cycles
`define ACRS_PWR_WAIT_MCLK  8
`define ACRS_RST_LOW_MCLK   1
`define ACRS_POST_RST_MCLK  2
`define ACRS_SYNC_LOW_MCLK  4

// filter settling interval, counted in core clock cycles
`define ACRS_SETTLE_CORE    64

// status word layout
`define ACRS_STAT_SETTLE_BIT 10

// register reset values
`define ACRS_GAIN_RST       16'hA000
`define ACRS_OVR_RST        16'hCCCC
`define ACRS_STAT_RST       16'h0000

`endif

// ==== acrs_pkg.sv ====
// acrs_pkg: types shared by both ends of the sequencer link.
// assumes acrs_regs.svh supplies the numeric constants.
package acrs_pkg;

  // register selector carried on the link
  typedef enum logic [1:0] {
    SEL_STATUS = 2'h0,
    SEL_GAIN   = 2'h1,
    SEL_OVR    = 2'h2
  } acrs_sel_t;

  // host start-up sequence, one-hot
  typedef enum logic [5:0] {
    H_OFF  = 6'h01,
    H_CLK  = 6'h02,
    H_RST  = 6'h04,
    H_WAIT = 6'h08,
    H_SYNC = 6'h10,
    H_RUN  = 6'h20
  } acrs_hstate_t;

endpackage : acrs_pkg

// ==== acrs_link_if.sv ====
// acrs_link_if: clock-run, reset, sync and register access lines
// between the host controller and the converter end.
// assumes one common clock; both ends sample on its rising edge.
`timescale 1ns/100ps
interface acrs_link_if;
  logic                mclk_run; // host has started the master clock
  logic                rst_n;    // reset, active low
  logic                sync_n;   // filter sync, active low
  logic                wr;       // one-cycle register write strobe
  logic                rd;       // one-cycle register read strobe
  acrs_pkg::acrs_sel_t sel;      // register selected
  logic [15:0]         wdata;    // write data
  logic [15:0]         rdata;    // read data
  logic                rvalid;   // read answer, one cycle
  logic                settled;  // filter settled, data valid

  modport dev (
    input  mclk_run, rst_n, sync_n, wr, rd, sel, wdata,
    output rdata, rvalid, settled
  );

  modport host (
    output mclk_run, rst_n, sync_n, wr, rd, sel, wdata,
    input  rdata, rvalid, settled
  );
endinterface : acrs_link_if

// ==== acrs_device.sv ====
// acrs_device: converter end; divides the master clock, polls reset
// and sync, tracks filter settling and holds gain and threshold.
// assumes the link lines change synchronously to REF_CLK_I.
`timescale 1ns/100ps
`include "acrs_regs.svh"
module acrs_device #(
  parameter int SETTLE_CYC = `ACRS_SETTLE_CORE
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  acrs_link_if.dev         lnk,
  output logic             CORE_CLK_O,
  output logic             POWER_OFF_HOLD_O,
  output logic             READY_O,
  output logic             DATA_VALID_O,
  output logic [15:0]      GAIN_O,
  output logic [15:0]      OVR_THR_O
);

  localparam int SW = $clog2(SETTLE_CYC + 1);

  logic          power_off_hold_r;
  logic          divided_core_clock_r;
  logic          sync_low_r;
  logic [1:0]    post_cnt_r;
  logic          ready_r;
  logic [SW-1:0] settle_cnt_r;
  logic          filter_settled_flag_r;
  logic [15:0]   gain_r;
  logic [15:0]   ovr_r;
  logic [15:0]   rdata_r;
  logic          rvalid_r;
  logic          wr_ok;

  // reset pin polled on each rising master edge; no edges while stopped
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      power_off_hold_r <= 1'b1;
    end else if (lnk.mclk_run) begin
      power_off_hold_r <= ~lnk.rst_n;
    end
  end

  // core clock is the master clock halved, stopped in power-down
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      divided_core_clock_r <= 1'b0;
    end else if (power_off_hold_r) begin
      divided_core_clock_r <= 1'b0;
    end else begin
      divided_core_clock_r <= ~divided_core_clock_r;
    end
  end

  // sync pin sampled once; inputs are already synchronous
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_low_r <= 1'b0;
    end else begin
      sync_low_r <= ~lnk.sync_n & ~power_off_hold_r;
    end
  end

  // access opens two master cycles after reset is seen released
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      post_cnt_r <= 2'h0;
      ready_r    <= 1'b0;
    end else if (power_off_hold_r) begin
      post_cnt_r <= 2'h0;
      ready_r    <= 1'b0;
    end else if (!ready_r) begin
      post_cnt_r <= post_cnt_r + 2'h1;
      ready_r    <= (post_cnt_r == 2'h1);
    end
  end

  // settling counts core ticks; reset or a sync pulse restarts it
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      settle_cnt_r          <= '0;
      filter_settled_flag_r <= 1'b0;
    end else if (power_off_hold_r || sync_low_r) begin
      settle_cnt_r          <= '0;
      filter_settled_flag_r <= 1'b0;
    end else if (ready_r && divided_core_clock_r &&
                 !filter_settled_flag_r) begin
      settle_cnt_r <= settle_cnt_r + SW'(1);
      filter_settled_flag_r <=
        (settle_cnt_r == SW'(SETTLE_CYC - 1));
    end
  end

  // writes are taken only once start-up is over and no sync is low
  assign wr_ok = lnk.wr & ready_r & ~sync_low_r;

  // gain and threshold keep their defaults until written
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      gain_r <= `ACRS_GAIN_RST;
      ovr_r  <= `ACRS_OVR_RST;
    end else if (power_off_hold_r) begin
      gain_r <= `ACRS_GAIN_RST;
      ovr_r  <= `ACRS_OVR_RST;
    end else if (wr_ok) begin
      if (lnk.sel == acrs_pkg::SEL_GAIN) begin
        gain_r <= lnk.wdata;
      end else if (lnk.sel == acrs_pkg::SEL_OVR) begin
        ovr_r <= lnk.wdata;
      end
    end
  end

  // read answer one cycle after the strobe; refused before ready
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= lnk.rd & ready_r;
      if (lnk.rd && ready_r) begin
        if (lnk.sel == acrs_pkg::SEL_GAIN) begin
          rdata_r <= gain_r;
        end else if (lnk.sel == acrs_pkg::SEL_OVR) begin
          rdata_r <= ovr_r;
        end else begin
          rdata_r <= `ACRS_STAT_RST;
          rdata_r[`ACRS_STAT_SETTLE_BIT] <= filter_settled_flag_r;
        end
      end
    end
  end

  assign lnk.rdata   = rdata_r;
  assign lnk.rvalid  = rvalid_r;
  assign lnk.settled = filter_settled_flag_r;

  assign CORE_CLK_O       = divided_core_clock_r;
  assign POWER_OFF_HOLD_O = power_off_hold_r;
  assign READY_O          = ready_r;
  assign DATA_VALID_O     = filter_settled_flag_r;
  assign GAIN_O           = gain_r;
  assign OVR_THR_O        = ovr_r;

endmodule : acrs_device

// ==== acrs_host.sv ====
// acrs_host: controller end; starts the clock, resets, optionally
// syncs, then forwards register accesses to the converter end.
// assumes START_I is raised only once supplies are up.
//
// Function
// - core clock is master clock halved
// - core clock stays at most 20 MHz
// - power, then clock, then reset
// - reset low at least one master cycle
// - reset changes clear of sampling edges
// - one common reset for all converters
// - wait two master cycles after reset
// - sync pulse to all, rising-edge aligned
// - no sync needed: hold sync high
// - no sync during a register write
// - sync low at least four master cycles
// - reads allowed with default gain, threshold
// - data invalid until filter settling ends
// - gain, threshold access after start-up
// - reset polled on rising master edges
// - reset low keeps converter powered down
// - settled flag in status bit ten
`timescale 1ns/100ps
`include "acrs_regs.svh"
module acrs_host #(
  parameter int PWR_WAIT = `ACRS_PWR_WAIT_MCLK,
  parameter int RST_LOW  = `ACRS_RST_LOW_MCLK,
  parameter int POST_RST = `ACRS_POST_RST_MCLK,
  parameter int SYNC_LOW = `ACRS_SYNC_LOW_MCLK
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  acrs_link_if.host        lnk,
  input  wire logic        START_I,
  input  wire logic        SYNC_EN_I,
  input  wire logic        SYNC_REQ_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [1:0]  SEL_I,
  input  wire logic [15:0] WDATA_I,
  output logic             READY_O,
  output logic             BUSY_O,
  output logic             SETTLED_O,
  output logic             RVALID_O,
  output logic [15:0]      RDATA_O
);

  // core rate check: divided master clock must not pass the ceiling
  localparam int CORE_HZ = `ACRS_MCLK_HZ / `ACRS_CORE_DIV;
  localparam bit CORE_OK = (CORE_HZ <= `ACRS_CORE_MAX_HZ);

  acrs_pkg::acrs_hstate_t state_r;
  acrs_pkg::acrs_hstate_t state_nxt;

  logic [15:0]         cnt_r;
  logic                cnt_done;
  logic                mclk_run_r;
  logic                rst_n_r;
  logic                sync_n_r;
  logic                wr_r;
  logic                rd_r;
  acrs_pkg::acrs_sel_t sel_r;
  logic [15:0]         wdata_r;
  logic                ready_r;
  logic                busy_r;
  logic                settled_r;
  logic                rvalid_r;
  logic [15:0]         rdata_r;
  logic                sync_go;

  // end of the current timed phase
  always_comb begin
    cnt_done = 1'b0;
    case (state_r)
      acrs_pkg::H_CLK:  cnt_done = (cnt_r == 16'(PWR_WAIT - 1));
      acrs_pkg::H_RST:  cnt_done = (cnt_r == 16'(RST_LOW - 1));
      acrs_pkg::H_WAIT: cnt_done = (cnt_r == 16'(POST_RST - 1));
      acrs_pkg::H_SYNC: cnt_done = (cnt_r == 16'(SYNC_LOW - 1));
      default:          cnt_done = 1'b0;
    endcase
  end

  // a resync is started only when no write is taken or in flight
  assign sync_go = SYNC_REQ_I & SYNC_EN_I & ~WR_I & ~wr_r;

  // start-up sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acrs_pkg::H_OFF: begin
        if (START_I && CORE_OK) begin
          state_nxt = acrs_pkg::H_CLK;
        end
      end
      acrs_pkg::H_CLK: begin
        if (cnt_done) begin
          state_nxt = acrs_pkg::H_RST;
        end
      end
      acrs_pkg::H_RST: begin
        if (cnt_done) begin
          state_nxt = acrs_pkg::H_WAIT;
        end
      end
      acrs_pkg::H_WAIT: begin
        if (cnt_done) begin
          state_nxt = SYNC_EN_I ? acrs_pkg::H_SYNC : acrs_pkg::H_RUN;
        end
      end
      acrs_pkg::H_SYNC: begin
        if (cnt_done) begin
          state_nxt = acrs_pkg::H_RUN;
        end
      end
      acrs_pkg::H_RUN: begin
        if (sync_go) begin
          state_nxt = acrs_pkg::H_SYNC;
        end
      end
      default: state_nxt = acrs_pkg::H_OFF;
    endcase
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= acrs_pkg::H_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // phase counter restarts on every state change
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // clock runs from the clock phase on; power is assumed already up
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mclk_run_r <= 1'b0;
    end else begin
      mclk_run_r <= (state_nxt != acrs_pkg::H_OFF);
    end
  end

  // one reset line; it fans out to every converter on the board
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rst_n_r <= 1'b1;
    end else begin
      rst_n_r <= (state_nxt != acrs_pkg::H_RST);
    end
  end

  // sync low only in the sync phase; held high when not wanted
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_n_r <= 1'b1;
    end else begin
      sync_n_r <= (state_nxt != acrs_pkg::H_SYNC);
    end
  end

  // accesses pass only in run; a read in the cycle a sync is scheduled still passes
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      sel_r   <= acrs_pkg::SEL_STATUS;
      wdata_r <= 16'h0000;
    end else begin
      wr_r <= WR_I & (state_r == acrs_pkg::H_RUN);
      rd_r <= RD_I & ~WR_I & (state_r == acrs_pkg::H_RUN);
      if ((WR_I || RD_I) && state_r == acrs_pkg::H_RUN) begin
        sel_r   <= acrs_pkg::acrs_sel_t'(SEL_I);
        wdata_r <= WDATA_I;
      end
    end
  end

  // status towards the user
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ready_r   <= 1'b0;
      busy_r    <= 1'b1;
      settled_r <= 1'b0;
    end else begin
      ready_r   <= (state_nxt == acrs_pkg::H_RUN);
      busy_r    <= (state_nxt != acrs_pkg::H_RUN);
      settled_r <= lnk.settled;
    end
  end

  // read answers are caught and presented one cycle later
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 16'h0000;
    end else begin
      rvalid_r <= lnk.rvalid;
      if (lnk.rvalid) begin
        rdata_r <= lnk.rdata;
      end
    end
  end

  // all link lines change just after a rising edge, far from the
  // next one; a true falling-edge launch would need a second clock
  assign lnk.mclk_run = mclk_run_r;
  assign lnk.rst_n    = rst_n_r;
  assign lnk.sync_n   = sync_n_r;
  assign lnk.wr       = wr_r;
  assign lnk.rd       = rd_r;
  assign lnk.sel      = sel_r;
  assign lnk.wdata    = wdata_r;

  assign READY_O   = ready_r;
  assign BUSY_O    = busy_r;
  assign SETTLED_O = settled_r;
  assign RVALID_O  = rvalid_r;
  assign RDATA_O   = rdata_r;

endmodule : acrs_host

// ==== acrs_checker.sv ====
// acrs_checker: timing checks on the host to converter link lines.
// assumes one clock; instantiated beside the link in the bench.
`timescale 1ns/100ps
module acrs_checker #(
  parameter int SETTLE_CYC = 64
) (
  input wire logic                REF_CLK_I,
  input wire logic                RST_I,
  input wire logic                mclk_run,
  input wire logic                rst_n,
  input wire logic                sync_n,
  input wire logic                wr,
  input wire logic                rd,
  input wire acrs_pkg::acrs_sel_t sel,
  input wire logic [15:0]         wdata,
  input wire logic [15:0]         rdata,
  input wire logic                rvalid,
  input wire logic                settled
);
  logic [7:0] quiet_r;

  // cycles since reset or sync last held the filter; saturates
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I)
      quiet_r <= 8'h00;
    else if (!(mclk_run && rst_n && sync_n))
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hFF)
      quiet_r <= quiet_r + 8'h01;
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);

  a_clock_before_rst: assert property (
    $fell(rst_n) |-> mclk_run ##1 rst_n) else $error("reset pulse bad");
  a_post_rst_quiet: assert property (
    $rose(rst_n) |-> (sync_n && !wr && !rd) [*2])
    else $error("access too soon after reset");
  a_sync_four_low: assert property (
    $fell(sync_n) |-> !sync_n [*4] ##1 sync_n)
    else $error("sync pulse width wrong");
  a_sync_no_write: assert property (
    !sync_n |-> !wr && !$past(wr)) else $error("sync during write");
  // the converter registers the pin first, so the flag drops two edges on
  a_sync_clears_flag: assert property (
    $fell(sync_n) |-> ##2 !settled) else $error("flag kept over sync");
  a_rst_clears_flag: assert property (
    !rst_n && mclk_run |-> ##2 !settled) else $error("flag kept in reset");
  a_read_answer: assert property (
    rd |=> rvalid) else $error("read not answered");
  a_answer_cause: assert property (
    rvalid |-> $past(rd)) else $error("answer without read");
  a_status_bit: assert property (
    rvalid && $past(sel) == acrs_pkg::SEL_STATUS |->
      rdata[15:11] == 5'h00 && rdata[9:0] == 10'h000 &&
      (rdata[10] == settled || rdata[10] == $past(settled)))
    else $error("status word wrong");
  a_settle_min: assert property (
    $rose(settled) |-> quiet_r >= SETTLE_CYC) else $error("settled early");
  a_settle_max: assert property (
    quiet_r == 2 * SETTLE_CYC + 8 |-> settled) else $error("settled late");

  // main scenarios reached
  c_settle: cover property ($rose(settled));
  c_sync: cover property ($fell(sync_n));
  c_read: cover property (rvalid && rdata[10]);
endmodule : acrs_checker

// ==== acrs_bench.sv ====
// acrs_bench: host and converter ends joined by the link, random
// register traffic, resync and a second start without sync.
// assumes the package, header and link interface are compiled first.
`timescale 1ns/100ps
module acrs_bench;
  localparam int SETTLE = 8;
  localparam int PWR    = 2;
  logic        clk, rst, start, sync_en, sync_req, wr, rd, prev;
  logic [1:0]  sel, s;
  logic [15:0] wdata, h_rdata, gain_o, ovr_o, exp_gain, exp_ovr, d;
  logic        h_ready, h_busy, h_settled, h_rvalid;
  logic        core_clk, pwr_hold, d_ready, d_valid;
  int          mismatches, n_checks, sync_lows, seed;

  acrs_link_if acrs_link_if_inst ();
  acrs_host #(.PWR_WAIT(PWR)) acrs_host_inst (.REF_CLK_I(clk),
    .RST_I(rst), .lnk(acrs_link_if_inst), .START_I(start),
    .SYNC_EN_I(sync_en), .SYNC_REQ_I(sync_req), .WR_I(wr), .RD_I(rd),
    .SEL_I(sel), .WDATA_I(wdata), .READY_O(h_ready), .BUSY_O(h_busy),
    .SETTLED_O(h_settled), .RVALID_O(h_rvalid), .RDATA_O(h_rdata));
  acrs_device #(.SETTLE_CYC(SETTLE)) acrs_device_inst (.REF_CLK_I(clk),
    .RST_I(rst), .lnk(acrs_link_if_inst), .CORE_CLK_O(core_clk),
    .POWER_OFF_HOLD_O(pwr_hold), .READY_O(d_ready),
    .DATA_VALID_O(d_valid), .GAIN_O(gain_o), .OVR_THR_O(ovr_o));
  acrs_checker #(.SETTLE_CYC(SETTLE)) acrs_checker_inst (
    .REF_CLK_I(clk), .RST_I(rst),
    .mclk_run(acrs_link_if_inst.mclk_run),
    .rst_n(acrs_link_if_inst.rst_n), .sync_n(acrs_link_if_inst.sync_n),
    .wr(acrs_link_if_inst.wr), .rd(acrs_link_if_inst.rd),
    .sel(acrs_link_if_inst.sel), .wdata(acrs_link_if_inst.wdata),
    .rdata(acrs_link_if_inst.rdata), .rvalid(acrs_link_if_inst.rvalid),
    .settled(acrs_link_if_inst.settled));

  // 20 MHz master clock
  always #25 clk = ~clk;

  // sync line must never pulse when no sync is wanted
  always @(posedge clk)
    if (!sync_en && acrs_link_if_inst.sync_n === 1'b0) sync_lows++;

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // start request, count edges until the host reports ready
  task automatic start_up(input int exp_cyc);
    int n;
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    while (h_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      start <= 1'b0;
      n++;
      #1;
    end
    check("ready latency", 16'(n), 16'(exp_cyc));
    check("busy", {15'h0000, h_busy}, 16'h0000);
  endtask : start_up

  task automatic rd_chk(input logic [1:0] rs, input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    rd <= 1'b1;
    sel <= rs;
    @(posedge clk);
    rd <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (h_rvalid !== 1'b1 && n < 8);
    check("read latency", 16'(n), 16'h0002);
    check("read data", h_rdata, exp);
  endtask : rd_chk

  // write then let the register settle two edges past the strobe
  task automatic wr_do(input logic [1:0] ws, input logic [15:0] wd);
    @(posedge clk);
    wr <= 1'b1;
    sel <= ws;
    wdata <= wd;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr_do

  task automatic wait_settle();
    int n;
    n = 0;
    while (h_settled !== 1'b1 && n < 8 * SETTLE + 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("settled", {15'h0000, d_valid}, 16'h0001);
    check("device ready", {15'h0000, d_ready}, 16'h0001);
  endtask : wait_settle

  initial begin
    clk = 0; rst = 1; start = 0; sync_en = 1; sync_req = 0; wr = 0;
    rd = 0; sel = 2'h0; wdata = 16'h0000; mismatches = 0; n_checks = 0;
    sync_lows = 0;
    seed = $urandom(52);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("hold", {15'h0000, pwr_hold}, 16'h0001);
    check("gain", gain_o, 16'hA000);
    start_up(PWR + 8);
    check("hold", {15'h0000, pwr_hold}, 16'h0000);
    rd_chk(2'h0, 16'h0000);
    rd_chk(2'h1, 16'hA000);
    rd_chk(2'h2, 16'hCCCC);
    prev = core_clk;
    // divided clock flips on every master edge
    repeat (4) begin
      @(posedge clk);
      #1;
      check("core clock", {15'h0000, core_clk}, {15'h0000, ~prev});
      prev = core_clk;
    end
    wait_settle();
    rd_chk(2'h0, 16'h0400);
    exp_gain = 16'hA000;
    exp_ovr = 16'hCCCC;
    // corner words first, then random ones
    for (int i = 0; i < 8; i++) begin
      s = ($urandom % 2) ? 2'h1 : 2'h2;
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
      if (i == 7) s = 2'h3;
      wr_do(s, d);
      if (s == 2'h1) exp_gain = d;
      if (s == 2'h2) exp_ovr = d;
      check("gain", gain_o, exp_gain);
      check("ovr", ovr_o, exp_ovr);
      if (s != 2'h3) rd_chk(s, d);
    end
    @(posedge clk);
    sync_req <= 1'b1;
    @(posedge clk);
    sync_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("flag after sync", {15'h0000, h_settled}, 16'h0000);
    wait_settle();
    @(posedge clk);
    rst <= 1'b1;
    sync_en <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr_do(2'h1, 16'h5555);
    check("gain refused", gain_o, 16'hA000);
    start_up(PWR + 4);
    wait_settle();
    check("sync pulses", 16'(sync_lows), 16'h0000);
    conclude();
  end

  // hang guard
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule : acrs_bench
